// >>> pkg/clock_gate_defines.vh
// Constants for the peripheral clock gating block: register offsets, field
// positions, reset values and the mask of implemented gating bits.
// Assumes it is included by bare name from design and checker files.
`ifndef CLOCK_GATE_DEFINES_VH
`define CLOCK_GATE_DEFINES_VH

// Byte offsets within the system control space.
`define RUN_CLOCK_GATE_1_OFS        12'h104
`define SLEEP_CLOCK_GATE_1_OFS      12'h114
`define DEEP_SLEEP_CLOCK_GATE_1_OFS 12'h124
`define RUN_MODE_CLOCK_CONFIG_OFS   12'h200
`define GATE_EVENT_STATUS_OFS       12'h208
`define GATE_EVENT_MASK_OFS         12'h20c

// System control base address.
`define SYS_CTRL_BASE               32'h400fe000

// Reset values.
`define GATE_RESET_VAL              32'h00000000
`define CONFIG_RESET_VAL            32'h00000000

// Writable gating bits; every other position is reserved and reads zero.
`define GATE_RW_MASK                32'h070f5137

// Field positions of the gating register.
`define ANALOG_CMP2_CLK_GATE_BIT        26
`define ANALOG_CMP1_CLK_GATE_BIT        25
`define ANALOG_CMP0_CLK_GATE_BIT        24
`define GP_COUNTER3_CLK_GATE_BIT        19
`define GP_COUNTER0_CLK_GATE_BIT        16
`define TWO_WIRE_PORT1_CLK_GATE_BIT     14
`define TWO_WIRE_PORT0_CLK_GATE_BIT     12
`define QUADRATURE_ENCODER_CLK_GATE_BIT 8
`define SYNC_SERIAL_PORT1_CLK_GATE_BIT  5
`define SYNC_SERIAL_PORT0_CLK_GATE_BIT  4
`define ASYNC_SERIAL_PORT2_CLK_GATE_BIT 2
`define ASYNC_SERIAL_PORT0_CLK_GATE_BIT 0

// Auto clock gating select bit in the run-mode clock configuration register.
`define AUTO_CLOCK_GATING_SELECT_BIT    0

// AHB transfer type bit that marks an active transfer.
`define HTRANS_ACTIVE_BIT           1
`define HRESP_OKAY                  1'b0

`endif

// >>> design/unit_clock_enable_select.v
// Picks the gating register that governs the unit clock enables in the
// present power state and registers the result.
// Assumes power state inputs are synchronous to ref_clk_i.
module unit_clock_enable_select #(
  parameter WIDTH = 32
) (
  input  wire             ref_clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] run_gate_i,
  input  wire [WIDTH-1:0] sleep_gate_i,
  input  wire [WIDTH-1:0] deep_gate_i,
  input  wire             auto_gate_i,
  input  wire             sleep_i,
  input  wire             deep_sleep_i,
  output reg  [WIDTH-1:0] unit_clk_en_o
);

  reg [WIDTH-1:0] sel_next;

  // Sleep copies only count with auto gating; otherwise the run copy rules.
  always @*
  begin
    if (deep_sleep_i && auto_gate_i)
      sel_next = deep_gate_i;
    else if (sleep_i && auto_gate_i)
      sel_next = sleep_gate_i;
    else
      sel_next = run_gate_i;
  end

  // Registered so the enable never glitches into the downstream cell.
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      unit_clk_en_o <= {WIDTH{1'b0}};
    else
      unit_clk_en_o <= sel_next;
  end

endmodule // unit_clock_enable_select

// >>> design/peripheral_clock_gating_deep_sleep.v
// Peripheral clock gating control with run, sleep and deep-sleep copies,
// an AHB-Lite register slave, unit access fault detection and an event interrupt.
// Assumes all inputs are synchronous to ref_clk_i and one AHB master.
//
// Contract
// - A gating bit of one gives its unit a clock enable, a zero removes it.
// - An access to a unit whose clock is gated off is answered with a fault.
// - The deep-sleep gating register reads zero after reset.
// - Run, sleep and deep-sleep gating registers share one bit layout.
// - Sleep and deep-sleep copies apply only when auto gating is selected.
// - The deep-sleep gating register is decoded at offset 0x124 of the base.
// - Bits 26, 25 and 24 gate analog comparators 2, 1 and 0, read and write.
// - Bits 5 and 4 gate synchronous serial ports 1 and 0, read and write.
// - Bits 2, 1 and 0 gate asynchronous serial ports 2, 1 and 0.
// - Reserved bits are read-only zero and software preserves them.
// - Bits 19 to 16 gate general-purpose counters 3 to 0, read and write.
// - Bits 14 and 12 gate two-wire ports 1 and 0, bit 8 the encoder.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`include "clock_gate_defines.vh"

module peripheral_clock_gating_deep_sleep #(
  parameter ADDR_WIDTH = 32,
  parameter DATA_WIDTH = 32
) (
  input  wire                  ref_clk_i,
  input  wire                  rst_i,
  // AHB-Lite slave port.
  input  wire                  hsel_i,
  input  wire [ADDR_WIDTH-1:0] haddr_i,
  input  wire [1:0]            htrans_i,
  input  wire                  hwrite_i,
  input  wire [2:0]            hsize_i,
  input  wire [DATA_WIDTH-1:0] hwdata_i,
  input  wire                  hready_i,
  output reg  [DATA_WIDTH-1:0] hrdata_o,
  output reg                   hreadyout_o,
  output reg                   hresp_o,
  // Power state from the power controller.
  input  wire                  sleep_i,
  input  wire                  deep_sleep_i,
  // Access attempts to gated units, one select bit per gating bit.
  input  wire                  unit_access_i,
  input  wire [DATA_WIDTH-1:0] unit_sel_i,
  output reg                   unit_fault_o,
  // Clock enables to the integrated clock gates of each unit.
  output wire [DATA_WIDTH-1:0] unit_clk_en_o,
  output reg                   irq_o
);

  // Masked update keeps reserved bits at zero in every gating copy.
  function [DATA_WIDTH-1:0] gate_write;
    input [DATA_WIDTH-1:0] wdata;
    begin
      gate_write = wdata & `GATE_RW_MASK;
    end
  endfunction

  // Address decode on the low twelve bits of the byte address.
  function hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Data phase state captured from the address phase.
  reg        dph_write_reg;
  reg        dph_write_next;
  reg [11:0] dph_addr_reg;
  reg [11:0] dph_addr_next;

  // Gating copies, configuration and event registers.
  reg [DATA_WIDTH-1:0] run_gate_reg;
  reg [DATA_WIDTH-1:0] run_gate_next;
  reg [DATA_WIDTH-1:0] sleep_gate_reg;
  reg [DATA_WIDTH-1:0] sleep_gate_next;
  reg [DATA_WIDTH-1:0] deep_gate_reg;
  reg [DATA_WIDTH-1:0] deep_gate_next;
  reg                  auto_gate_reg;
  reg                  auto_gate_next;
  reg [DATA_WIDTH-1:0] status_reg;
  reg [DATA_WIDTH-1:0] status_next;
  reg [DATA_WIDTH-1:0] mask_reg;
  reg [DATA_WIDTH-1:0] mask_next;
  reg [DATA_WIDTH-1:0] rdata_next;
  reg                  fault_next;
  reg [DATA_WIDTH-1:0] fault_set;

  wire addr_phase;
  wire wr_en;

  // A transfer is taken when selected, active and the bus is ready.
  assign addr_phase = hsel_i && htrans_i[`HTRANS_ACTIVE_BIT] && hready_i;
  assign wr_en      = dph_write_reg;

  // The address phase is latched; a zero wait slave needs nothing more.
  always @*
  begin
    dph_write_next = 1'b0;
    dph_addr_next  = dph_addr_reg;
    if (addr_phase)
    begin
      dph_write_next = hwrite_i;
      dph_addr_next  = haddr_i[11:0];
    end
  end

  // Software writes land in the data phase; reserved bits never store.
  always @*
  begin
    run_gate_next   = run_gate_reg;
    sleep_gate_next = sleep_gate_reg;
    deep_gate_next  = deep_gate_reg;
    auto_gate_next  = auto_gate_reg;
    mask_next       = mask_reg;
    if (wr_en)
    begin
      if (hit(dph_addr_reg, `RUN_CLOCK_GATE_1_OFS))
        run_gate_next = gate_write(hwdata_i);
      if (hit(dph_addr_reg, `SLEEP_CLOCK_GATE_1_OFS))
        sleep_gate_next = gate_write(hwdata_i);
      if (hit(dph_addr_reg, `DEEP_SLEEP_CLOCK_GATE_1_OFS))
        deep_gate_next = gate_write(hwdata_i);
      if (hit(dph_addr_reg, `RUN_MODE_CLOCK_CONFIG_OFS))
        auto_gate_next = hwdata_i[`AUTO_CLOCK_GATING_SELECT_BIT];
      if (hit(dph_addr_reg, `GATE_EVENT_MASK_OFS))
        mask_next = gate_write(hwdata_i);
    end
  end

  // An access to an unclocked unit is a fault and flags the unit's event.
  always @*
  begin
    fault_set  = {DATA_WIDTH{1'b0}};
    fault_next = 1'b0;
    if (unit_access_i)
    begin
      fault_set  = unit_sel_i & ~unit_clk_en_o & `GATE_RW_MASK;
      fault_next = |(unit_sel_i & ~unit_clk_en_o);
    end
  end

  // Status bits clear on a written one, but a same-cycle event wins.
  always @*
  begin
    status_next = status_reg;
    if (wr_en && hit(dph_addr_reg, `GATE_EVENT_STATUS_OFS))
      status_next = status_reg & ~hwdata_i;
    status_next = status_next | fault_set;
  end

  // Read data is built from next values so a read right after a write
  // returns the new contents; unmapped offsets read zero.
  always @*
  begin
    rdata_next = {DATA_WIDTH{1'b0}};
    if (addr_phase && !hwrite_i)
    begin
      case (haddr_i[11:0])
        `RUN_CLOCK_GATE_1_OFS:        rdata_next = run_gate_next;
        `SLEEP_CLOCK_GATE_1_OFS:      rdata_next = sleep_gate_next;
        `DEEP_SLEEP_CLOCK_GATE_1_OFS: rdata_next = deep_gate_next;
        `RUN_MODE_CLOCK_CONFIG_OFS:   rdata_next[`AUTO_CLOCK_GATING_SELECT_BIT] = auto_gate_next;
        `GATE_EVENT_STATUS_OFS:       rdata_next = status_next;
        `GATE_EVENT_MASK_OFS:         rdata_next = mask_next;
        default:                      rdata_next = {DATA_WIDTH{1'b0}};
      endcase
    end
  end

  // All registers reset to zero, so every unit starts unclocked.
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dph_write_reg  <= 1'b0;
      dph_addr_reg   <= 12'h000;
      run_gate_reg   <= `GATE_RESET_VAL;
      sleep_gate_reg <= `GATE_RESET_VAL;
      deep_gate_reg  <= `GATE_RESET_VAL;
      auto_gate_reg  <= 1'b0;
      status_reg     <= `GATE_RESET_VAL;
      mask_reg       <= `GATE_RESET_VAL;
    end
    else
    begin
      dph_write_reg  <= dph_write_next;
      dph_addr_reg   <= dph_addr_next;
      run_gate_reg   <= run_gate_next;
      sleep_gate_reg <= sleep_gate_next;
      deep_gate_reg  <= deep_gate_next;
      auto_gate_reg  <= auto_gate_next;
      status_reg     <= status_next;
      mask_reg       <= mask_next;
    end
  end

  // Bus answers and outputs come straight from flops.
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hrdata_o     <= {DATA_WIDTH{1'b0}};
      hreadyout_o  <= 1'b1;
      hresp_o      <= `HRESP_OKAY;
      unit_fault_o <= 1'b0;
      irq_o        <= 1'b0;
    end
    else
    begin
      hrdata_o     <= rdata_next;
      hreadyout_o  <= 1'b1;
      hresp_o      <= `HRESP_OKAY;
      unit_fault_o <= fault_next;
      irq_o        <= |(status_next & mask_next);
    end
  end

  // Power-state selection of the effective enables.
  unit_clock_enable_select #(
    .WIDTH (DATA_WIDTH)
  ) u_enable_select (
    .ref_clk_i     (ref_clk_i),
    .rst_i         (rst_i),
    .run_gate_i    (run_gate_reg),
    .sleep_gate_i  (sleep_gate_reg),
    .deep_gate_i   (deep_gate_reg),
    .auto_gate_i   (auto_gate_reg),
    .sleep_i       (sleep_i),
    .deep_sleep_i  (deep_sleep_i),
    .unit_clk_en_o (unit_clk_en_o)
  );

endmodule // peripheral_clock_gating_deep_sleep

// >>> dv/clock_gate_sva.sv
// Assertion checker for the peripheral clock gating block.
// Assumes it sees only the top module ports and the shared defines header.
`include "clock_gate_defines.vh"
module clock_gate_sva #(
  parameter ADDR_WIDTH = 32,
  parameter DATA_WIDTH = 32
) (
  input wire logic                  ref_clk_i,
  input wire logic                  rst_i,
  input wire logic                  hsel_i,
  input wire logic [ADDR_WIDTH-1:0] haddr_i,
  input wire logic [1:0]            htrans_i,
  input wire logic                  hwrite_i,
  input wire logic                  hready_i,
  input wire logic [DATA_WIDTH-1:0] hrdata_o,
  input wire logic                  hreadyout_o,
  input wire logic                  hresp_o,
  input wire logic                  sleep_i,
  input wire logic                  deep_sleep_i,
  input wire logic                  unit_access_i,
  input wire logic [DATA_WIDTH-1:0] unit_sel_i,
  input wire logic                  unit_fault_o,
  input wire logic [DATA_WIDTH-1:0] unit_clk_en_o,
  input wire logic                  irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Register bus transfers taken at an edge.
  wire rd_a = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
  wire wr_a = hsel_i & htrans_i[1] & hready_i & hwrite_i;
  property p_fault_match;
    unit_access_i |=> unit_fault_o == $past(|(unit_sel_i & ~unit_clk_en_o));
  endproperty
  a_fault_match: assert property (p_fault_match)
    else $error("fault does not follow the gated selection");
  property p_fault_idle;
    !unit_access_i |=> !unit_fault_o;
  endproperty
  a_fault_idle: assert property (p_fault_idle)
    else $error("fault without an access");
  property p_en_resv;
    (unit_clk_en_o & ~`GATE_RW_MASK) == 32'h0;
  endproperty
  a_en_resv: assert property (p_en_resv)
    else $error("enable on a reserved position");
  property p_rd_resv;
    rd_a && haddr_i[11:0] == `DEEP_SLEEP_CLOCK_GATE_1_OFS |=> (hrdata_o & ~`GATE_RW_MASK) == 32'h0;
  endproperty
  a_rd_resv: assert property (p_rd_resv)
    else $error("reserved bit read back nonzero");
  property p_rst_val;
    $past(rst_i) |-> unit_clk_en_o == 32'h0 && !irq_o;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("outputs not clear after reset");
  property p_en_hold;
    (!wr_a && $stable({sleep_i, deep_sleep_i}))[*3] |=>
      $stable({sleep_i, deep_sleep_i}) |-> $stable(unit_clk_en_o);
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("enable moved with no cause");
  property p_irq_rise;
    $rose(irq_o) |-> unit_fault_o || $past(wr_a) || $past(wr_a, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose with no fault or write");
  property p_bus_okay;
    hreadyout_o && hresp_o == `HRESP_OKAY;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus not ready or not okay");
endmodule // clock_gate_sva

bind peripheral_clock_gating_deep_sleep clock_gate_sva #(
  .ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) sva_u (.ref_clk_i, .rst_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .sleep_i,
  .deep_sleep_i, .unit_access_i, .unit_sel_i, .unit_fault_o, .unit_clk_en_o, .irq_o);

// >>> dv/unit_port_model.sv
// Model of the gated units as seen by the block: one access attempt per call.
// Assumes the caller enters the task off a clock edge or right after one.
module unit_port_model (
  input  wire logic        clk_i,
  input  wire logic        fault_i,
  output logic             access_o,
  output logic [31:0]      sel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Select idles low before any traffic.
  initial
  begin
    access_o = 1'b0;
    sel_o = 32'h0;
  end
  // Leaves the inverse select behind so a stale unit number is never reused.
  task automatic access(input logic [31:0] sel, output logic fault);
    @(posedge clk_i);
    access_o <= 1'b1;
    sel_o <= sel;
    @(posedge clk_i);
    access_o <= 1'b0;
    sel_o <= ~sel;
    #1 fault = fault_i; // Answer shows just after the taking edge
  endtask
endmodule // unit_port_model

// >>> dv/tb_top.sv
// Self-checking bench for the peripheral clock gating block.
// Assumes a single bus master and the unit model on the access side.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic sleep_i = 1'b0, deep_sleep_i = 1'b0, hreadyout_o, hresp_o;
  logic unit_access_i, unit_fault_o, irq_o, f;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, unit_sel_i, unit_clk_en_o;
  logic [1:0] htrans_i = 2'b00;
  int n_mismatch = 0, check_count = 0;
  // Free-running 250 MHz clock.
  always #2 ref_clk_i = ~ref_clk_i;
  peripheral_clock_gating_deep_sleep dut_u (.ref_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(3'b010), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
    .hresp_o, .sleep_i, .deep_sleep_i, .unit_access_i, .unit_sel_i, .unit_fault_o,
    .unit_clk_en_o, .irq_o);
  unit_port_model units_u (.clk_i(ref_clk_i), .fault_i(unit_fault_o), .access_o(unit_access_i),
    .sel_o(unit_sel_i));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One single word transfer; the data line is scrambled while it carries nothing.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge ref_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    hwrite_i <= w;
    haddr_i <= {20'h400fe, a};
    hwdata_i <= ~hwdata_i;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk($sformatf("reg %h", a), x, e);
  endtask
  // Enables follow a power state change within one edge; three are allowed.
  task automatic pw(input logic s, input logic d, input logic [31:0] e);
    @(posedge ref_clk_i);
    sleep_i <= s;
    deep_sleep_i <= d;
    repeat (3) @(posedge ref_clk_i);
    #1 chk("enables", unit_clk_en_o, e);
  endtask
  task automatic t_reset();
    rdc(12'h124, 32'h0);
    rdc(12'h104, 32'h0);
    chk("enables", unit_clk_en_o, 32'h0);
  endtask
  task automatic t_layout();
    logic [11:0] ofs[3] = '{12'h104, 12'h114, 12'h124};
    foreach (ofs[i])
    begin
      wr(ofs[i], 32'hffffffff);
      rdc(ofs[i], 32'h070f5137);
    end
    wr(12'h300, 32'hffffffff);
    rdc(12'h300, 32'h0);
  endtask
  task automatic t_select();
    wr(12'h104, 32'h00000001);
    wr(12'h114, 32'h00000010);
    wr(12'h124, 32'h01000000);
    wr(12'h200, 32'h0);
    pw(1'b0, 1'b1, 32'h00000001);
    wr(12'h200, 32'h1);
    pw(1'b0, 1'b1, 32'h01000000);
    pw(1'b1, 1'b0, 32'h00000010);
    pw(1'b0, 1'b0, 32'h00000001);
  endtask
  // Faults raise the sticky status; the mask gates the interrupt.
  task automatic t_fault();
    pw(1'b0, 1'b1, 32'h01000000);
    units_u.access(32'h01000000, f);
    chk("fault", {31'h0, f}, 32'h0);
    units_u.access(32'h00000001, f);
    chk("fault", {31'h0, f}, 32'h1);
    rdc(12'h208, 32'h1);
    #1 chk("irq", {31'h0, irq_o}, 32'h0);
    wr(12'h20c, 32'h1);
    #1 chk("irq", {31'h0, irq_o}, 32'h1);
    wr(12'h208, 32'h1);
    rdc(12'h208, 32'h0);
    #1 chk("irq", {31'h0, irq_o}, 32'h0);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence after 20 cycles of reset.
  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_layout();
    t_select();
    t_fault();
    end_sim();
  end
  // The tests need about a hundred cycles; this cuts a hang far beyond that.
  initial
  begin
    #20000;
    n_mismatch++;
    end_sim();
  end
endmodule // tb_top
